/* File: bench/ptm_timer_asserts.sv */
// Checker of bus handshake, match pulse and irq timing
`timescale 1ns/1ps
module ptm_timer_asserts (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        sleep,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        period_match_pulse,
   input wire logic        match_irq_req
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic irq_wr;
   logic rd_ok;
   assign irq_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
                   && avs_address == ptm_pkg::OFF_IRQ;
   assign rd_ok  = avs_read && !avs_waitrequest;
   sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
   property p_wait; $rose(avs_read || avs_write) |-> s_one_wait; endproperty
   a_wait: assert property (p_wait) else $error("wait not one cycle");
   property p_idle; !(avs_read || avs_write) |=> avs_waitrequest;
   endproperty
   a_idle: assert property (p_idle) else $error("idle wait low");
   property p_gap; period_match_pulse |=> !period_match_pulse [*3];
   endproperty
   a_gap: assert property (p_gap) else $error("pulses too close");
   property p_sleep; sleep [*6] |-> !period_match_pulse; endproperty
   a_sleep: assert property (p_sleep) else $error("pulse in sleep");
   property p_rd_hi; rd_ok |-> avs_readdata[31:8] == 24'h00_0000;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("upper bits set");
   property p_unmap; rd_ok && avs_address[1:0] != 2'b00
      |-> avs_readdata == ptm_pkg::UNMAPPED_DATA; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped data");
   property p_rst; $fell(rst) |-> !period_match_pulse && !match_irq_req;
   endproperty
   a_rst: assert property (p_rst) else $error("output after reset");
   property p_irq_off; irq_wr && !avs_writedata[1] |=> ##1 !match_irq_req;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq masked");
   property p_irq_rise; $rose(match_irq_req) |-> period_match_pulse
      || $past(period_match_pulse) || $past(irq_wr && avs_writedata[1], 2);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq cause");
endmodule : ptm_timer_asserts
bind ptm_timer ptm_timer_asserts u_chk (.clock, .rst, .sleep, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .period_match_pulse, .match_irq_req);

/* File: bench/ptm_timer_tb.sv */
// Testbench of the period timer against an integer model
`timescale 1ns/1ps
module ptm_timer_tb;
   logic        clock;
   logic        rst;
   logic        sleep;
   logic        avs_read;
   logic        avs_write;
   logic [3:0]  avs_address;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic [31:0] rv;
   logic        avs_waitrequest;
   logic        period_match_pulse;
   logic        match_irq_req;
   int          failures = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          n;
   int          m;
   int          t;
   int          per;
   int          v;
   int          mdl_count = 0;
   int          mdl_period = 255;
   int          mdl_ctl = 0;
   int          mdl_flag = 0;
   int          mdl_en = 0;
   int          stamps[$];
   int          divs[4] = '{1, 4, 16, 64};
   int          posts[4] = '{0, 15, 2, 1};

   ptm_timer dut (.clock, .rst, .sleep, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .period_match_pulse, .match_irq_req);

   initial begin
      clock = 1'b0;
      forever begin
         #4 clock = ~clock;
      end
   end

   task summarize;
      if (failures == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // Hang guard, several times the longest expected run
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         summarize();
      end
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask : chk

   task wr(input logic [3:0] a, input logic [7:0] d);
      avs_address   <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write     <= 1'b1;
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      // Model: the write lands on the edge that ends the wait
      if (avs_byteenable[0] === 1'b1) begin
         case (a)
            ptm_pkg::OFF_COUNT:   mdl_count  = d;
            ptm_pkg::OFF_PERIOD:  mdl_period = d;
            ptm_pkg::OFF_CONTROL: mdl_ctl    = d[6:0];
            ptm_pkg::OFF_IRQ: begin
               mdl_flag = d[0];
               mdl_en   = d[1];
            end
            default: ;
         endcase
      end
      @(posedge clock);
   endtask : wr

   task rd(input logic [3:0] a);
      avs_address <= a;
      avs_read    <= 1'b1;
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      rv = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask : rd

   initial begin
      rst            = 1'b1;
      sleep          = 1'b0;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_address    = 4'h0;
      avs_writedata  = 32'h0000_0000;
      avs_byteenable = 4'h1;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      v = $urandom(13998);
      @(posedge clock);
      rd(ptm_pkg::OFF_COUNT);
      chk("count", mdl_count, rv);
      avs_byteenable <= 4'h0;
      wr(ptm_pkg::OFF_PERIOD, 8'h00);
      avs_byteenable <= 4'h1;
      wr(4'h2, 8'h5a);
      rd(ptm_pkg::OFF_PERIOD);
      chk("period", mdl_period, rv);
      rd(4'h2);
      chk("unmapped", 0, rv);
      // Nonzero, so a count wrongly cleared by a control write shows
      v = 1 + $urandom % 255;
      wr(ptm_pkg::OFF_COUNT, 8'(v));
      rd(ptm_pkg::OFF_COUNT);
      chk("count", mdl_count, rv);
      wr(ptm_pkg::OFF_CONTROL, 8'h7b);
      rd(ptm_pkg::OFF_COUNT);
      chk("count", mdl_count, rv);
      for (int p = 0; p < 4; p++) begin
         per = 1 + $urandom % 3;
         // Stop first, so no match of the old setup sets the flag
         wr(ptm_pkg::OFF_CONTROL, 8'h00);
         wr(ptm_pkg::OFF_PERIOD, 8'(per));
         wr(ptm_pkg::OFF_COUNT, 8'h00);
         wr(ptm_pkg::OFF_IRQ, 8'h02);
         wr(ptm_pkg::OFF_CONTROL, {1'b0, 4'(posts[p]), 1'b1, 2'(p)});
         n = 0;
         m = 0;
         t = 0;
         stamps.delete();
         while (m == 0 || n < 2) begin
            @(posedge clock);
            t++;
            if (period_match_pulse === 1'b1) begin
               n++;
               stamps.push_back(t);
               if (n == posts[p] + 1) begin
                  mdl_flag = 1;
               end
            end
            if (match_irq_req === 1'b1 && m == 0) begin
               m = n;
            end
         end
         v = stamps[1] - stamps[0];
         chk("gap", 4 * divs[p] * (mdl_period + 1), v);
         chk("post", posts[p] + 1, m);
         rd(ptm_pkg::OFF_IRQ);
         chk("flag", 2 * mdl_en + mdl_flag, rv);
         wr(ptm_pkg::OFF_IRQ, 8'h01);
         // Request is registered: look two edges after the mask lands
         @(posedge clock);
         chk("irq", mdl_flag & mdl_en, match_irq_req);
      end
      wr(ptm_pkg::OFF_PERIOD, 8'hff);
      wr(ptm_pkg::OFF_CONTROL, 8'h04);
      sleep <= 1'b1;
      repeat (4) @(posedge clock);
      rd(ptm_pkg::OFF_COUNT);
      v = rv;
      repeat (40) @(posedge clock);
      rd(ptm_pkg::OFF_COUNT);
      chk("sleep", v, rv);
      rd(ptm_pkg::OFF_PERIOD);
      chk("sleep period", mdl_period, rv);
      sleep <= 1'b0;
      repeat (40) @(posedge clock);
      rd(ptm_pkg::OFF_COUNT);
      chk("moving", 1, rv != v);
      wr(ptm_pkg::OFF_CONTROL, 8'h00);
      rd(ptm_pkg::OFF_COUNT);
      v = rv;
      repeat (40) @(posedge clock);
      rd(ptm_pkg::OFF_COUNT);
      chk("frozen", v, rv);
      summarize();
   end
endmodule : ptm_timer_tb

/* File: hdl/ptm_pkg.sv */
// Package of register map, field layout and types for the period timer
package ptm_pkg;
   localparam int          ADDR_W            = 4;
   localparam logic [3:0]  OFF_COUNT         = 4'h0;
   localparam logic [3:0]  OFF_PERIOD        = 4'h4;
   localparam logic [3:0]  OFF_CONTROL       = 4'h8;
   localparam logic [3:0]  OFF_IRQ           = 4'hc;
   localparam logic [7:0]  COUNT_RESET       = 8'h00;
   localparam logic [7:0]  PERIOD_RESET      = 8'hff;
   localparam logic [6:0]  CONTROL_RESET     = 7'h00;
   localparam int          CTL_PRE_LSB       = 0;
   localparam int          CTL_RUN_BIT       = 2;
   localparam int          CTL_POST_LSB      = 3;
   localparam int          IRQ_FLAG_BIT      = 0;
   localparam int          IRQ_EN_BIT        = 1;
   localparam int          INSTR_DIV         = 4;
   localparam logic [1:0]  INSTR_DIV_LAST    = 2'(INSTR_DIV - 1);
   localparam logic [31:0] UNMAPPED_DATA     = 32'h0000_0000;

   typedef struct packed {
      logic [3:0] post_sel;
      logic       run;
      logic [1:0] pre_sel;
   } ptm_ctl_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } ptm_req_t;
endpackage : ptm_pkg

/* File: hdl/ptm_postscaler.sv */
// Postscaler: counts match pulses, fires every post_sel+1 matches
`timescale 1ns/1ps
module ptm_postscaler (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       match,
   input  wire logic [3:0] post_sel,
   output logic            fire
);
   logic [3:0] post_ff;

   assign fire = match && (post_ff == post_sel);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         post_ff <= 4'h0;
      end else if (clear) begin
         post_ff <= 4'h0;
      end else if (match) begin
         post_ff <= (post_ff == post_sel) ? 4'h0 : post_ff + 4'h1;
      end
   end
endmodule : ptm_postscaler

/* File: hdl/ptm_prescaler.sv */
// Prescaler: instruction clock divider and selectable 1/4/16/64 divider
`timescale 1ns/1ps
module ptm_prescaler (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       advance,
   input  wire logic [1:0] pre_sel,
   output logic            tick
);
   logic [1:0] phase_ff;
   logic [5:0] pre_ff;
   logic       instr_edge;
   logic       pre_done;

   // Fosc/4 instruction clock edge
   assign instr_edge = (phase_ff == ptm_pkg::INSTR_DIV_LAST);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   always_comb begin
      unique case (pre_sel)
         2'b00: pre_done = 1'b1;
         2'b01: pre_done = (pre_ff[1:0] == 2'h3);
         2'b10: pre_done = (pre_ff[3:0] == 4'hf);
         2'b11: pre_done = (pre_ff == 6'h3f);
      endcase
   end

   assign tick = advance && instr_edge && pre_done;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre_ff <= 6'h00;
      end else if (clear) begin
         pre_ff <= 6'h00;
      end else if (advance && instr_edge) begin
         pre_ff <= pre_done ? 6'h00 : pre_ff + 6'h01;
      end
   end
endmodule : ptm_prescaler

/* File: hdl/ptm_timer.sv */
// Top of the 8-bit period timer with prescaler, postscaler, Avalon slave
// Operation
// - Timer ticks only from instruction clock, system clock divided by four.
// - Count register increments by one per prescaled tick, from zero.
// - Prescale select 00/01/10/11 divides by 1, 4, 16, 64.
// - Count compared with period each timer cycle; equality gives match.
// - After match count returns to zero next tick; match advances postscaler.
// - Any reset clears count and loads period with all ones.
// - Scalers clear on count write, control write, and every reset.
// - Control write leaves the count value unchanged.
// - Postscaler counts matches and sets latched flag at selected count.
// - Postscale select gives ratio equal to value plus one.
// - Interrupt request raised from flag only while enable bit set.
// - Match pulse is system-clock synchronous and exported to peripherals.
// - During sleep the timer does not count; registers hold.
// - Software reads and writes count and period at any time.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module ptm_timer (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        sleep,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             period_match_pulse,
   output logic             match_irq_req
);
   ptm_pkg::ptm_req_t  req;
   ptm_pkg::ptm_ctl_t  ctl_ff;
   logic [7:0]         count_ff;
   logic [7:0]         period_ff;
   logic               flag_ff;
   logic               irq_en_ff;
   logic               sleep_s1_ff;
   logic               sleep_s2_ff;
   logic               wait_ff;
   logic [31:0]        rdata_ff;
   logic               match_ff;
   logic               irq_ff;
   logic               access;
   logic               wr_take;
   logic               wr_count;
   logic               wr_period;
   logic               wr_control;
   logic               wr_irq;
   logic               scaler_clear;
   logic               advance;
   logic               tick;
   logic               match;
   logic               fire;
   logic               lane0;
   logic [31:0]        nxt_rdata;

   assign req = '{read: avs_read, write: avs_write,
                  address: avs_address, writedata: avs_writedata};

   // Sleep arrives from the core domain boundary; two stages first
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sleep_s1_ff <= 1'b0;
         sleep_s2_ff <= 1'b0;
      end else begin
         sleep_s1_ff <= sleep;
         sleep_s2_ff <= sleep_s1_ff;
      end
   end

   // Wait from a flop: high while idle, so every access sees one wait
   assign access  = (req.read || req.write) && wait_ff;
   // Write lands on the edge that ends the wait, not before
   assign wr_take = req.write && !wait_ff;
   assign lane0   = avs_byteenable[0];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= !access;
      end
   end

   assign avs_waitrequest = wait_ff;

   assign wr_count   = wr_take && lane0
                       && (req.address == ptm_pkg::OFF_COUNT);
   assign wr_period  = wr_take && lane0
                       && (req.address == ptm_pkg::OFF_PERIOD);
   assign wr_control = wr_take && lane0
                       && (req.address == ptm_pkg::OFF_CONTROL);
   assign wr_irq     = wr_take && lane0
                       && (req.address == ptm_pkg::OFF_IRQ);

   assign scaler_clear = wr_count || wr_control;
   assign advance = ctl_ff.run && !sleep_s2_ff;

   ptm_prescaler u_pre (
      .clock   (clock),
      .rst     (rst),
      .clear   (scaler_clear),
      .advance (advance),
      .pre_sel (ctl_ff.pre_sel),
      .tick    (tick)
   );

   // Compare each timer cycle
   assign match = tick && (count_ff == period_ff);

   ptm_postscaler u_post (
      .clock    (clock),
      .rst      (rst),
      .clear    (scaler_clear),
      .match    (match),
      .post_sel (ctl_ff.post_sel),
      .fire     (fire)
   );

   // Count register; a software write beats a same-cycle tick
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_ff <= ptm_pkg::COUNT_RESET;
      end else if (wr_count) begin
         count_ff <= req.writedata[7:0];
      end else if (match) begin
         count_ff <= ptm_pkg::COUNT_RESET;
      end else if (tick) begin
         count_ff <= count_ff + 8'h01;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         period_ff <= ptm_pkg::PERIOD_RESET;
      end else if (wr_period) begin
         period_ff <= req.writedata[7:0];
      end
   end

   // Control write loads control and clears both scalers; count keeps its value
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctl_ff <= ptm_pkg::CONTROL_RESET;
      end else if (wr_control) begin
         ctl_ff <= req.writedata[6:0];
      end
   end

   // Flag: hardware set wins over a same-cycle software clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flag_ff <= 1'b0;
      end else if (fire) begin
         flag_ff <= 1'b1;
      end else if (wr_irq) begin
         flag_ff <= req.writedata[ptm_pkg::IRQ_FLAG_BIT];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_en_ff <= 1'b0;
      end else if (wr_irq) begin
         irq_en_ff <= req.writedata[ptm_pkg::IRQ_EN_BIT];
      end
   end

   // Registered outputs, one cycle after the cause
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         match_ff <= 1'b0;
         irq_ff   <= 1'b0;
      end else begin
         match_ff <= match;
         irq_ff   <= flag_ff && irq_en_ff;
      end
   end

   assign period_match_pulse = match_ff;
   assign match_irq_req      = irq_ff;

   always_comb begin
      unique case (req.address)
         ptm_pkg::OFF_COUNT:   nxt_rdata = {24'h00_0000, count_ff};
         ptm_pkg::OFF_PERIOD:  nxt_rdata = {24'h00_0000, period_ff};
         ptm_pkg::OFF_CONTROL: nxt_rdata = {25'h000_0000, ctl_ff};
         ptm_pkg::OFF_IRQ:     nxt_rdata = {30'h0000_0000, irq_en_ff,
                                            flag_ff};
         default:              nxt_rdata = ptm_pkg::UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (req.read && wait_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign avs_readdata = rdata_ff;
endmodule : ptm_timer
